// >>> hdl/scdma_map.vh
// Register map, field positions and constants of the single channel transfer engine.
// Assumes inclusion by the engine's design files only.
`ifndef SCDMA_MAP_VH
`define SCDMA_MAP_VH

// ****************************************
// Register word addresses (byte offsets)
// ****************************************
`define SCDMA_ADDR_W 4
`define SCDMA_OFS_CTRL 4'h0
`define SCDMA_OFS_SRC 4'h4
`define SCDMA_OFS_DST 4'h8
`define SCDMA_OFS_TYPE 4'hC

// ****************************************
// Control register fields
// ****************************************
`define SCDMA_CTRL_EN 0
`define SCDMA_CTRL_AUTO 1
`define SCDMA_CTRL_FENCE 2
`define SCDMA_CTRL_ERR_RD 8
`define SCDMA_CTRL_ERR_WR 9
`define SCDMA_CTRL_BUSY 10
`define SCDMA_CTRL_DONE 11
`define SCDMA_CTRL_TRIG_TYPE 15
`define SCDMA_CTRL_SEL_LSB 16
`define SCDMA_CTRL_SEL_MSB 19

// ****************************************
// Transfer type register fields
// ****************************************
`define SCDMA_TYPE_NUM_MSB 23
`define SCDMA_TYPE_QSEL_LSB 27
`define SCDMA_TYPE_QSEL_MSB 28
`define SCDMA_TYPE_SRC_INC 29
`define SCDMA_TYPE_DST_INC 30
`define SCDMA_TYPE_ENDIAN 31

// ****************************************
// Quantity encodings and misc constants
// ****************************************
`define SCDMA_Q_B2B 2'h0
`define SCDMA_Q_B2ZW 2'h1
`define SCDMA_Q_B2SW 2'h2
`define SCDMA_Q_W2W 2'h3
`define SCDMA_DONE_IRQ_CH 10
`define SCDMA_NUM_FAST_INTERRUPT_LINE 16
`define SCDMA_ZERO32 32'h00000000
`define SCDMA_ZERO24 24'h000000
`define SCDMA_ONE24 24'h000001
`define SCDMA_STEP_B 32'h00000001
`define SCDMA_STEP_W 32'h00000004
`define SCDMA_BE_ALL 4'hF
`define SCDMA_BE_B0 4'h1

`endif

// >>> hdl/scdma_conv.v
// Element converter: size change, lane placement and optional byte order swap.
// Assumes purely combinational use inside the engine, sampled on the write step.
`timescale 1ns/1ps
`include "scdma_map.vh"

module scdma_conv
(
  input wire [1:0] qsel,
  input wire swap,
  input wire [1:0] src_lane,
  input wire [1:0] dst_lane,
  input wire [31:0] rdata,
  output reg [31:0] wdata,
  output reg [3:0] wbe
);

  reg [7:0] rbyte;
  reg [31:0] word;

  always @*
  begin
    rbyte = rdata[8 * src_lane +: 8];
    case (qsel)
      `SCDMA_Q_B2B: word = {24'h000000, rbyte};
      `SCDMA_Q_B2ZW: word = {24'h000000, rbyte};
      `SCDMA_Q_B2SW: word = {{24{rbyte[7]}}, rbyte};
      default: word = rdata;
    endcase
    // Swap reverses the whole word; byte-to-byte stores skip it and keep the byte as read
    if (swap && (qsel != `SCDMA_Q_B2B))
      word = {word[7:0], word[15:8], word[23:16], word[31:24]};
    if (qsel == `SCDMA_Q_B2B)
    begin
      wdata = {4{word[7:0]}};
      wbe = `SCDMA_BE_B0 << dst_lane;
    end
    else
    begin
      wdata = word;
      wbe = `SCDMA_BE_ALL;
    end
  end

endmodule // scdma_conv

// >>> hdl/scdma_top.v
// Single channel memory-to-memory transfer engine with register port and bus master.
// Assumes one 50 MHz clock, a bus that grants when the CPU is idle and answers with ack or err.
//
// Contract
// - One channel, configured by registers only
// - Completion signalled on fast interrupt 10
// - Request bus only when CPU idle
// - Control, source, destination, type registers
// - Runs only while enable bit set
// - Manual mode: type write starts transfer
// - Auto mode: selected fast interrupt starts
// - Element atomic; disable stops after element
// - Bus error sets read/write flag, aborts
// - Address registers show failing address
// - Count field shows failing element index; count_q holds the elements left, failing one included
// - Error flags cleared on new start
// - Done flag set after transfer executes
// - Any control write clears done; a completion, error or empty start in the same cycle keeps it set
// - Size conversion and byte swap supported
// - Quantity select field picks conversion
// - Increment bits advance addresses per element
// - Trigger type: rising edge or level
// - Interrupt on error too; pending until done cleared
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "scdma_map.vh"

module scdma_top
(
  input wire sys_clk,
  input wire rst_n,
  input wire clk_en,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata_q,
  input wire [15:0] fast_interrupt_line,
  input wire cpu_bus_req,
  output reg bus_req_q,
  output reg bus_we_q,
  output reg [31:0] bus_addr_q,
  output reg [31:0] bus_wdata_q,
  output reg [3:0] bus_be_q,
  input wire [31:0] bus_rdata,
  input wire bus_ack,
  input wire bus_err,
  output reg fence_q,
  output reg done_irq_q
);

  // ****************************************
  // States
  // ****************************************
  localparam ST_IDLE = 2'b00;
  localparam ST_READ = 2'b01;
  localparam ST_WRITE = 2'b10;
  localparam ST_NEXT = 2'b11;

  // ****************************************
  // Registers
  // ****************************************
  reg [1:0] state_q;
  reg en_q;
  reg auto_q;
  reg fence_en_q;
  reg trig_type_q;
  reg [3:0] sel_q;
  reg err_rd_q;
  reg err_wr_q;
  reg done_q;
  reg [31:0] source_address_register_q;
  reg [31:0] destination_address_register_q;
  reg [23:0] count_q;
  reg [1:0] quantity_select_field_q;
  reg source_increment_bit_q;
  reg destination_increment_bit_q;
  reg swap_q;
  reg [31:0] rdata_q;
  reg [15:0] fast_interrupt_line_s1_q;
  reg [15:0] fast_interrupt_line_s2_q;
  reg fast_interrupt_line_prev_q;
  reg start_pend_q;

  wire [31:0] conv_wdata;
  wire [3:0] conv_be;
  wire busy;
  wire fast_interrupt_line_sel;
  wire auto_trig;
  wire ctrl_wr;
  wire type_wr;
  wire start;
  wire [31:0] ctrl_view;
  wire [31:0] type_view;

  // Address step for one element of the given size
  function [31:0] step_of;
    input word_sz;
    begin
      step_of = word_sz ? `SCDMA_STEP_W : `SCDMA_STEP_B;
    end
  endfunction

  assign busy = (state_q != ST_IDLE);
  assign fast_interrupt_line_sel = fast_interrupt_line_s2_q[sel_q];
  assign ctrl_wr = reg_wr && (reg_addr == `SCDMA_OFS_CTRL);
  assign type_wr = reg_wr && (reg_addr == `SCDMA_OFS_TYPE);
  assign auto_trig = trig_type_q ? fast_interrupt_line_sel : (fast_interrupt_line_sel && !fast_interrupt_line_prev_q);
  assign start = en_q && !busy && (auto_q ? auto_trig : start_pend_q);

  // Four software registers; reserved bits read as zero
  assign ctrl_view = {12'h000, sel_q, trig_type_q, 3'h0, done_q, busy, err_wr_q, err_rd_q,
                      5'h00, fence_en_q, auto_q, en_q};
  assign type_view = {swap_q, destination_increment_bit_q, source_increment_bit_q,
                      quantity_select_field_q, 3'h0, count_q};

  scdma_conv u_conv
  (
    .qsel(quantity_select_field_q),
    .swap(swap_q),
    .src_lane(source_address_register_q[1:0]),
    .dst_lane(destination_address_register_q[1:0]),
    .rdata(rdata_q),
    .wdata(conv_wdata),
    .wbe(conv_be)
  );

  // ****************************************
  // Fast interrupt synchroniser
  // ****************************************
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      fast_interrupt_line_s1_q <= 16'h0000;
      fast_interrupt_line_s2_q <= 16'h0000;
      fast_interrupt_line_prev_q <= 1'b0;
    end
    else if (clk_en)
    begin
      fast_interrupt_line_s1_q <= fast_interrupt_line;
      fast_interrupt_line_s2_q <= fast_interrupt_line_s1_q;
      fast_interrupt_line_prev_q <= fast_interrupt_line_sel;
    end
  end

  // ****************************************
  // Register port, read side
  // ****************************************
  always @(posedge sys_clk)
  begin
    if (!rst_n)
      reg_rdata_q <= `SCDMA_ZERO32;
    else if (clk_en)
    begin
      if (!reg_rd)
        reg_rdata_q <= `SCDMA_ZERO32;
      else if (reg_addr == `SCDMA_OFS_CTRL)
        reg_rdata_q <= ctrl_view;
      else if (reg_addr == `SCDMA_OFS_SRC)
        reg_rdata_q <= source_address_register_q;
      else if (reg_addr == `SCDMA_OFS_DST)
        reg_rdata_q <= destination_address_register_q;
      else if (reg_addr == `SCDMA_OFS_TYPE)
        reg_rdata_q <= type_view;
      else
        reg_rdata_q <= `SCDMA_ZERO32;
    end
  end

  // ****************************************
  // Control and transfer engine
  // ****************************************
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_q <= ST_IDLE;
      en_q <= 1'b0;
      auto_q <= 1'b0;
      fence_en_q <= 1'b0;
      trig_type_q <= 1'b0;
      sel_q <= 4'h0;
      err_rd_q <= 1'b0;
      err_wr_q <= 1'b0;
      done_q <= 1'b0;
      source_address_register_q <= `SCDMA_ZERO32;
      destination_address_register_q <= `SCDMA_ZERO32;
      count_q <= `SCDMA_ZERO24;
      quantity_select_field_q <= `SCDMA_Q_B2B;
      source_increment_bit_q <= 1'b0;
      destination_increment_bit_q <= 1'b0;
      swap_q <= 1'b0;
      rdata_q <= `SCDMA_ZERO32;
      start_pend_q <= 1'b0;
      bus_req_q <= 1'b0;
      bus_we_q <= 1'b0;
      bus_addr_q <= `SCDMA_ZERO32;
      bus_wdata_q <= `SCDMA_ZERO32;
      bus_be_q <= 4'h0;
      fence_q <= 1'b0;
      done_irq_q <= 1'b0;
    end
    else if (clk_en)
    begin
      fence_q <= 1'b0;
      done_irq_q <= done_q;
      if (ctrl_wr)
      begin
        en_q <= reg_wdata[`SCDMA_CTRL_EN];
        auto_q <= reg_wdata[`SCDMA_CTRL_AUTO];
        fence_en_q <= reg_wdata[`SCDMA_CTRL_FENCE];
        trig_type_q <= reg_wdata[`SCDMA_CTRL_TRIG_TYPE];
        sel_q <= reg_wdata[`SCDMA_CTRL_SEL_MSB:`SCDMA_CTRL_SEL_LSB];
        done_q <= 1'b0;
      end
      // Address and type registers are frozen while a transfer runs so the counters stay coherent
      if (reg_wr && !busy && (reg_addr == `SCDMA_OFS_SRC))
        source_address_register_q <= reg_wdata;
      if (reg_wr && !busy && (reg_addr == `SCDMA_OFS_DST))
        destination_address_register_q <= reg_wdata;
      if (type_wr && !busy)
      begin
        count_q <= reg_wdata[`SCDMA_TYPE_NUM_MSB:0];
        quantity_select_field_q <= reg_wdata[`SCDMA_TYPE_QSEL_MSB:`SCDMA_TYPE_QSEL_LSB];
        source_increment_bit_q <= reg_wdata[`SCDMA_TYPE_SRC_INC];
        destination_increment_bit_q <= reg_wdata[`SCDMA_TYPE_DST_INC];
        swap_q <= reg_wdata[`SCDMA_TYPE_ENDIAN];
      end
      if (type_wr && !busy && !auto_q)
        start_pend_q <= 1'b1;
      else if (start || auto_q || (ctrl_wr && !reg_wdata[`SCDMA_CTRL_EN]))
        start_pend_q <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (start)
          begin
            err_rd_q <= 1'b0;
            err_wr_q <= 1'b0;
            if (count_q == `SCDMA_ZERO24)
            begin
              // Empty transfer completes at once
              done_q <= 1'b1;
            end
            else
              state_q <= ST_READ;
          end
        end
        ST_READ:
        begin
          if (!bus_req_q && !cpu_bus_req)
          begin
            bus_req_q <= 1'b1;
            bus_we_q <= 1'b0;
            bus_addr_q <= {source_address_register_q[31:2], 2'b00};
            bus_be_q <= `SCDMA_BE_ALL;
          end
          else if (bus_req_q && (bus_ack || bus_err))
          begin
            bus_req_q <= 1'b0;
            rdata_q <= bus_rdata;
            if (bus_err)
            begin
              err_rd_q <= 1'b1;
              done_q <= 1'b1;
              state_q <= ST_IDLE;
            end
            else
              state_q <= ST_WRITE;
          end
        end
        ST_WRITE:
        begin
          if (!bus_req_q && !cpu_bus_req)
          begin
            bus_req_q <= 1'b1;
            bus_we_q <= 1'b1;
            bus_addr_q <= {destination_address_register_q[31:2], 2'b00};
            bus_wdata_q <= conv_wdata;
            bus_be_q <= conv_be;
          end
          else if (bus_req_q && (bus_ack || bus_err))
          begin
            bus_req_q <= 1'b0;
            bus_we_q <= 1'b0;
            if (bus_err)
            begin
              err_wr_q <= 1'b1;
              done_q <= 1'b1;
              state_q <= ST_IDLE;
            end
            else
              state_q <= ST_NEXT;
          end
        end
        default:
        begin
          // Element boundary: the only point where a disable takes effect
          if (source_increment_bit_q)
            source_address_register_q <= source_address_register_q +
              step_of(quantity_select_field_q == `SCDMA_Q_W2W);
          if (destination_increment_bit_q)
            destination_address_register_q <= destination_address_register_q +
              step_of(quantity_select_field_q != `SCDMA_Q_B2B);
          count_q <= count_q - `SCDMA_ONE24;
          if ((count_q == `SCDMA_ONE24) || !en_q)
          begin
            state_q <= ST_IDLE;
            done_q <= 1'b1;
            fence_q <= fence_en_q && (count_q == `SCDMA_ONE24);
          end
          else
            state_q <= ST_READ;
        end
      endcase
    end
  end

endmodule // scdma_top

// >>> tb/scdma_checker.sv
// Port checker for the transfer engine top level.
// Assumes one clock domain and clk_en held high.
`timescale 1ns/1ps
module scdma_checker
(
  input wire sys_clk,
  input wire rst_n,
  input wire [3:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata_q,
  input wire cpu_bus_req,
  input wire bus_req_q,
  input wire bus_we_q,
  input wire [31:0] bus_addr_q,
  input wire [3:0] bus_be_q,
  input wire bus_ack,
  input wire bus_err,
  input wire done_irq_q
);
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> !bus_req_q && !done_irq_q)
    else $error("active after reset");
  a_cpu_first: assert property ($rose(bus_req_q) |-> !$past(cpu_bus_req))
    else $error("request over cpu");
  a_req_hold: assert property (bus_req_q && !bus_ack && !bus_err |=> bus_req_q && $stable(bus_addr_q))
    else $error("request dropped early");
  a_req_drop: assert property (bus_req_q && (bus_ack || bus_err) |=> !bus_req_q)
    else $error("request kept after answer");
  a_err_irq: assert property (bus_req_q && bus_err |-> ##[1:4] done_irq_q)
    else $error("no irq on error");
  a_irq_pending: assert property (done_irq_q && !reg_wr && !$past(reg_wr) |=> done_irq_q)
    else $error("irq lost");
  a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata_q == 32'h0)
    else $error("read data outside slot");
  a_rd_hole: assert property (reg_rd && reg_addr[1:0] != 2'h0 |=> reg_rdata_q == 32'h0)
    else $error("hole read nonzero");
  a_ctrl_reserved: assert property (reg_rd && reg_addr == 4'h0 |=> (reg_rdata_q & 32'hFFF070F8) == 32'h0)
    else $error("reserved bits set");
  a_read_lanes: assert property (bus_req_q && !bus_we_q |-> bus_be_q == 4'hF && bus_addr_q[1:0] == 2'h0)
    else $error("bad read lanes");
endmodule // scdma_checker

bind scdma_top scdma_checker scdma_checker_i (.*);

// >>> tb/scdma_bus_model.sv
// Bus partner: 16-word memory answering with ack or err.
// Assumes addresses below 0x40; the 0xE region always faults.
`timescale 1ns/1ps
module scdma_bus_model
(
  input wire sys_clk,
  input wire slow,
  input wire bus_req_q,
  input wire bus_we_q,
  input wire [31:0] bus_addr_q,
  input wire [31:0] bus_wdata_q,
  input wire [3:0] bus_be_q,
  output reg [31:0] bus_rdata,
  output reg bus_ack,
  output reg bus_err
);
  reg [31:0] mem [0:15];
  reg [1:0] wait_q = 2'h0;
  integer i;
  // ****************
  // Access handling
  // ****************
  initial
  begin
    bus_rdata = 32'h0;
    bus_ack = 1'b0;
    bus_err = 1'b0;
  end
  // Stale read data is inverted so a late sample cannot pass
  always @(posedge sys_clk)
  begin
    bus_ack <= 1'b0;
    bus_err <= 1'b0;
    bus_rdata <= ~bus_rdata;
    if (bus_req_q && !bus_ack && !bus_err)
    begin
      if (wait_q != 2'h0)
        wait_q <= wait_q - 2'h1;
      else if (bus_addr_q[31:28] == 4'hE)
        bus_err <= 1'b1;
      else
      begin
        bus_ack <= 1'b1;
        bus_rdata <= mem[bus_addr_q[5:2]];
        for (i = 0; i < 4; i = i + 1)
          if (bus_we_q && bus_be_q[i])
            mem[bus_addr_q[5:2]][8*i +: 8] <= bus_wdata_q[8*i +: 8];
      end
    end
    else
      wait_q <= slow ? 2'h2 : 2'h0;
  end
endmodule // scdma_bus_model

// >>> tb/tb_top.sv
// Self-checking bench for the transfer engine.
// Assumes the bus model and the bound checker.
`timescale 1ns/1ps
module tb_top;
  reg sys_clk = 1'b0;
  reg rst_n = 1'b0;
  reg [3:0] reg_addr = 4'h0;
  reg [31:0] reg_wdata = 32'h0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [15:0] fast_interrupt_line = 16'h0;
  reg cpu_bus_req = 1'b0;
  reg slow = 1'b0;
  reg rd_d = 1'b0;
  wire [31:0] reg_rdata_q, bus_addr_q, bus_wdata_q, bus_rdata;
  wire bus_req_q, bus_we_q, bus_ack, bus_err, done_irq_q, fence_q;
  integer fences = 0;
  wire [3:0] bus_be_q;
  integer miscompares = 0;
  integer comparisons = 0;
  integer cyc = 0;
  integer k, n;
  reg [31:0] eq [$];
  reg [31:0] mq [$];
  reg [31:0] w, x;
  // ****************
  // Harness
  // ****************
  always #10 sys_clk = ~sys_clk;
  scdma_top scdma_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .fast_interrupt_line(fast_interrupt_line), .cpu_bus_req(cpu_bus_req), .bus_req_q(bus_req_q),
    .bus_we_q(bus_we_q), .bus_addr_q(bus_addr_q), .bus_wdata_q(bus_wdata_q), .bus_be_q(bus_be_q),
    .bus_rdata(bus_rdata), .bus_ack(bus_ack), .bus_err(bus_err), .fence_q(fence_q), .done_irq_q(done_irq_q));
  scdma_bus_model scdma_bus_model_i (.sys_clk(sys_clk), .slow(slow), .bus_req_q(bus_req_q),
    .bus_we_q(bus_we_q), .bus_addr_q(bus_addr_q), .bus_wdata_q(bus_wdata_q), .bus_be_q(bus_be_q),
    .bus_rdata(bus_rdata), .bus_ack(bus_ack), .bus_err(bus_err));
  task check(input [39:0] nm, input [31:0] seen, input [31:0] exp);
  begin
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      miscompares = miscompares + 1;
      $display("unexpected %0s expected %h seen %h", nm, exp, seen);
    end
  end
  endtask
  task report_and_stop;
  begin
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  task wr(input [3:0] a, input [31:0] d);
  begin
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  end
  endtask
  task rd(input [3:0] a, input [31:0] e, input [31:0] m);
  begin
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    eq.push_back(e);
    mq.push_back(m);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  end
  endtask
  task wait_irq(input v);
  begin
    n = 0;
    while (done_irq_q !== v && n < 300)
    begin
      @(negedge sys_clk);
      n = n + 1;
    end
    check("irq", {31'h0, done_irq_q}, {31'h0, v});
  end
  endtask
  function [31:0] conv(input [1:0] q, input s, input [31:0] w, input [31:0] x);
    reg [7:0] b;
  begin
    b = w[15:8];
    case (q)
      2'h0: conv = {x[31:16], b, x[7:0]};
      2'h1: conv = {24'h0, b};
      2'h2: conv = {{24{b[7]}}, b};
      default: conv = w;
    endcase
    if (s && q != 2'h0)
      conv = {conv[7:0], conv[15:8], conv[23:16], conv[31:24]};
  end
  endfunction
  // Read data is judged one cycle after the strobe, on the falling edge
  always @(posedge sys_clk)
  begin
    rd_d <= reg_rd;
    cpu_bus_req <= ($urandom % 4) == 0;
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      miscompares = miscompares + 1;
      report_and_stop;
    end
  end
  // Fence pulses are counted away from the launching edge
  always @(negedge sys_clk)
    if (fence_q)
      fences = fences + 1;
  always @(negedge sys_clk)
    if (rd_d)
    begin
      check("rdata", reg_rdata_q & mq[0], eq[0] & mq[0]);
      eq.delete(0);
      mq.delete(0);
    end
  // ****************
  // Scenarios
  // ****************
  initial
  begin
    k = $urandom(43143);
    for (k = 0; k < 16; k = k + 1)
      scdma_bus_model_i.mem[k] = $urandom;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(4'h0, 32'h0, 32'hFFFFFFFF);
    rd(4'h2, 32'h0, 32'hFFFFFFFF);
    wr(4'h4, 32'h0);
    wr(4'h8, 32'h20);
    wr(4'hC, 32'h78000002);
    repeat (20) @(negedge sys_clk);
    check("idle", {31'h0, bus_req_q}, 32'h0);
    wr(4'h0, 32'h1);
    wait_irq(1'b1);
    check("mem8", scdma_bus_model_i.mem[8], scdma_bus_model_i.mem[0]);
    check("mem9", scdma_bus_model_i.mem[9], scdma_bus_model_i.mem[1]);
    rd(4'h0, 32'h801, 32'hF01);
    rd(4'h4, 32'h8, 32'hFFFFFFFF);
    rd(4'h8, 32'h28, 32'hFFFFFFFF);
    wr(4'h0, 32'h1);
    wait_irq(1'b0);
    for (k = 0; k < 8; k = k + 1)
    begin
      w = scdma_bus_model_i.mem[1];
      x = scdma_bus_model_i.mem[9];
      wr(4'h4, k[1:0] == 2'h3 ? 32'h4 : 32'h5);
      wr(4'h8, k[1:0] == 2'h0 ? 32'h25 : 32'h24);
      wr(4'hC, {k[2], 2'b00, k[1:0], 27'h1});
      wait_irq(1'b1);
      check("conv", scdma_bus_model_i.mem[9], conv(k[1:0], k[2], w, x));
      wr(4'h0, 32'h1);
      wait_irq(1'b0);
    end
    wr(4'h4, 32'hE0000000);
    wr(4'hC, 32'h18000003);
    wait_irq(1'b1);
    rd(4'h0, 32'h901, 32'hF01);
    rd(4'h4, 32'hE0000000, 32'hFFFFFFFF);
    rd(4'hC, 32'h18000003, 32'hFFFFFFFF);
    wr(4'h0, 32'h5);
    wr(4'h4, 32'h0);
    wr(4'h8, 32'hE0000010);
    wr(4'hC, 32'h18000002);
    wait_irq(1'b1);
    rd(4'h0, 32'hA05, 32'hF05);
    rd(4'h8, 32'hE0000010, 32'hFFFFFFFF);
    rd(4'hC, 32'h18000002, 32'hFFFFFFFF);
    check("nofence", fences, 0);
    slow <= 1'b1;
    wr(4'h8, 32'h30);
    wr(4'h0, 32'h50007);
    wr(4'hC, 32'h18000001);
    wait_irq(1'b0);
    repeat (20) @(negedge sys_clk);
    check("auto", {31'h0, done_irq_q}, 32'h0);
    fast_interrupt_line <= 16'h0020;
    wait_irq(1'b1);
    check("mem12", scdma_bus_model_i.mem[12], scdma_bus_model_i.mem[0]);
    check("fence", fences, 1);
    wr(4'h0, 32'h50003);
    repeat (30) @(negedge sys_clk);
    check("edge", {31'h0, done_irq_q}, 32'h0);
    wr(4'h0, 32'h58003);
    wait_irq(1'b1);
    wr(4'h0, 32'h0);
    fast_interrupt_line <= 16'h0;
    // Disable lands while level starts repeat: the empty start in the write cycle sets done again, busy stays clear
    repeat (60) @(posedge sys_clk);
    rd(4'h0, 32'h800, 32'hC01);
    repeat (20) @(posedge sys_clk);
    report_and_stop;
  end
endmodule // tb_top
